// *** core/icc_ctrl.sv ***
// Purpose: Twelve-source interrupt controller with AHB-Lite register access
// Assumes: Single clock hclk, core gives instruction-cycle and return pulses
// Notes:   Zero-wait writes, one-wait reads
//
// What this block does
// - Twelve sources, pins and internal events, each set their own software-visible request flag.
// - After reset every source is disabled until software enables it.
// - Four priority levels come from the two priority registers.
// - Priority is set per group of two sources, six groups as paired in polling order.
// - Pins A and B request on low level, or on a falling edge when selected in the timer control register.
// - Pins C and D trigger on falling edge or optionally rising; pins E, F and G on rising edge only.
// - Timer C capture and compare events set the flags of pins D to G.
// - A condition sets its flag even when the source is disabled.
// - Flags are sampled by hardware every cycle.
// - A pending enabled request forces a long call to its vector at the next instruction cycle.
// - An active service routine is preempted only by a strictly higher level.
// - The return instruction ends service at the current level and reopens lower preemption.
// - Least latency is seven cycles, one to detect and six for the long call.
// - Only the timer A and timer B overflow flags clear by hardware when their routine is called.
// - Sources are polled in a fixed order from pin A to pin G.
// - Each source has its fixed vector address.
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`include "icc_defines.svh"
module icc_ctrl (
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic [31:0]              hrdata,
   output logic                     hresp,
   input  wire logic                ext_irq_pin_a,
   input  wire logic                ext_irq_pin_b,
   input  wire logic                ext_irq_pin_c,
   input  wire logic                ext_irq_pin_d,
   input  wire logic                ext_irq_pin_e,
   input  wire logic                ext_irq_pin_f,
   input  wire logic                ext_irq_pin_g,
   input  wire icc_pkg::icc_periph_s periph_evt,
   input  wire icc_pkg::icc_core_s   core_in,
   output icc_pkg::icc_call_s        call_out,
   output logic [3:0]               svc_levels,
   output logic                     irq
);
   import icc_pkg::*;

   // Bus state
   icc_bus_e                  bus_st_r;
   icc_bus_e                  bus_st_nxt;
   logic [`ICC_ADDR_W-1:0]    addr_r;
   logic                      hreadyout_r;
   logic [31:0]               hrdata_r;

   // Registers
   logic [7:0]                timer_control_reg_r;
   logic [7:0]                irq_request_reg_r;
   logic [7:0]                timer_c_control_reg_r;
   logic [7:0]                serial_a_control_reg_r;
   logic [7:0]                serial_b_control_reg_r;
   logic [7:0]                irq_enable_reg_a_r;
   logic [7:0]                irq_enable_reg_b_r;
   logic [7:0]                irq_enable_reg_c_r;
   logic [7:0]                irq_priority_reg_a_r;
   logic [7:0]                irq_priority_reg_b_r;
   logic [`ICC_NSRC-1:0]      evt_st_r;
   logic [`ICC_NSRC-1:0]      evt_mask_r;
   logic                      irq_r;

   // Call sequencing
   logic [3:0]                svc_r;
   logic                      sel_ok_r;
   logic [3:0]                sel_idx_r;
   logic [1:0]                sel_lvl_r;
   logic [2:0]                busy_cnt_r;
   icc_call_s                 call_r;

   // Pin detectors
   logic [`ICC_NPIN-1:0]      pin_raw;
   logic [`ICC_NPIN-1:0]      pin_low;
   logic [`ICC_NPIN-1:0]      pin_rise;
   logic [`ICC_NPIN-1:0]      pin_fall;

   assign pin_raw = {ext_irq_pin_g, ext_irq_pin_f, ext_irq_pin_e, ext_irq_pin_d,
                     ext_irq_pin_c, ext_irq_pin_b, ext_irq_pin_a};

   // One synchroniser and edge detector per pin
   genvar gp;
   generate
      for (gp = 0; gp < `ICC_NPIN; gp++) begin : g_pin
         icc_pin_edge u_edge (
            .hclk     (hclk),
            .hresetn  (hresetn),
            .pin_raw  (pin_raw[gp]),
            .pin_low  (pin_low[gp]),
            .pin_rise (pin_rise[gp]),
            .pin_fall (pin_fall[gp])
         );
      end
   endgenerate

   // Address phase and decode
   wire                       addr_ok  = hsel & htrans[1] & hready;
   wire                       wr_now   = (bus_st_r == ST_WR);
   wire [7:0]                 wd       = hwdata[7:0];
   wire                       wr_tc    = wr_now & (addr_r == `ICC_OFS_TIMER_CTRL);
   wire                       wr_ir    = wr_now & (addr_r == `ICC_OFS_IRQ_REQUEST);
   wire                       wr_t2    = wr_now & (addr_r == `ICC_OFS_TIMER_C_CTRL);
   wire                       wr_sa    = wr_now & (addr_r == `ICC_OFS_SERIAL_A_CTRL);
   wire                       wr_sb    = wr_now & (addr_r == `ICC_OFS_SERIAL_B_CTRL);
   wire                       wr_ea    = wr_now & (addr_r == `ICC_OFS_ENABLE_A);
   wire                       wr_eb    = wr_now & (addr_r == `ICC_OFS_ENABLE_B);
   wire                       wr_ec    = wr_now & (addr_r == `ICC_OFS_ENABLE_C);
   wire                       wr_pa    = wr_now & (addr_r == `ICC_OFS_PRIO_A);
   wire                       wr_pb    = wr_now & (addr_r == `ICC_OFS_PRIO_B);
   wire                       wr_es    = wr_now & (addr_r == `ICC_OFS_EVT_STATUS);
   wire                       wr_em    = wr_now & (addr_r == `ICC_OFS_EVT_MASK);

   // Trigger conditions
   wire set_ext_a = timer_control_reg_r[`ICC_TC_EDGE_A] ? pin_fall[0] : pin_low[0];
   wire set_ext_b = timer_control_reg_r[`ICC_TC_EDGE_B] ? pin_fall[1] : pin_low[1];
   wire set_ext_c = timer_c_control_reg_r[`ICC_T2_RISE_C] ? pin_rise[2] : pin_fall[2];
   wire set_ext_d = (timer_c_control_reg_r[`ICC_T2_RISE_D] ? pin_rise[3] : pin_fall[3])
                    | periph_evt.cc_evt[0];
   wire set_ext_e = pin_rise[4] | periph_evt.cc_evt[1];
   wire set_ext_f = pin_rise[5] | periph_evt.cc_evt[2];
   wire set_ext_g = pin_rise[6] | periph_evt.cc_evt[3];

   // Hardware sets, in register layout
   wire [7:0] tc_set = ({7'h00, set_ext_a} << `ICC_TC_FLAG_A) | ({7'h00, set_ext_b} << `ICC_TC_FLAG_B)
                     | ({7'h00, periph_evt.timer_a_ovf} << `ICC_TC_TIMER_A)
                     | ({7'h00, periph_evt.timer_b_ovf} << `ICC_TC_TIMER_B);
   wire [7:0] ir_set = ({7'h00, set_ext_c} << `ICC_IR_EXT_C) | ({7'h00, set_ext_d} << `ICC_IR_EXT_D)
                     | ({7'h00, set_ext_e} << `ICC_IR_EXT_E) | ({7'h00, set_ext_f} << `ICC_IR_EXT_F)
                     | ({7'h00, set_ext_g} << `ICC_IR_EXT_G)
                     | ({7'h00, periph_evt.timer_c_ext} << `ICC_IR_TIMER_C_EXT)
                     | ({7'h00, periph_evt.timer_c_ovf} << `ICC_IR_TIMER_C_OVF);
   wire [7:0] sa_set = ({7'h00, periph_evt.serial_a_rx} << `ICC_SC_RX)
                     | ({7'h00, periph_evt.serial_a_tx} << `ICC_SC_TX);
   wire [7:0] sb_set = ({7'h00, periph_evt.serial_b_rx} << `ICC_SC_RX)
                     | ({7'h00, periph_evt.serial_b_tx} << `ICC_SC_TX);

   // Request per source in polling order
   wire [`ICC_NSRC-1:0] req = {
      irq_request_reg_r[`ICC_IR_EXT_G],
      irq_request_reg_r[`ICC_IR_TIMER_C_OVF] | irq_request_reg_r[`ICC_IR_TIMER_C_EXT],
      irq_request_reg_r[`ICC_IR_EXT_F],
      serial_a_control_reg_r[`ICC_SC_RX] | serial_a_control_reg_r[`ICC_SC_TX],
      irq_request_reg_r[`ICC_IR_EXT_E],
      timer_control_reg_r[`ICC_TC_TIMER_B],
      irq_request_reg_r[`ICC_IR_EXT_D],
      timer_control_reg_r[`ICC_TC_FLAG_B],
      irq_request_reg_r[`ICC_IR_EXT_C],
      timer_control_reg_r[`ICC_TC_TIMER_A],
      serial_b_control_reg_r[`ICC_SC_RX] | serial_b_control_reg_r[`ICC_SC_TX],
      timer_control_reg_r[`ICC_TC_FLAG_A]};

   // Raw condition events for the event status, same order
   wire [`ICC_NSRC-1:0] evt_set = {
      set_ext_g, periph_evt.timer_c_ovf | periph_evt.timer_c_ext, set_ext_f,
      periph_evt.serial_a_rx | periph_evt.serial_a_tx, set_ext_e, periph_evt.timer_b_ovf,
      set_ext_d, set_ext_b, set_ext_c, periph_evt.timer_a_ovf,
      periph_evt.serial_b_rx | periph_evt.serial_b_tx, set_ext_a};

   wire [`ICC_NSRC-1:0] en = {
      irq_enable_reg_b_r[`ICC_EB_EXT_G], irq_enable_reg_a_r[`ICC_EA_TIMER_C],
      irq_enable_reg_b_r[`ICC_EB_EXT_F], irq_enable_reg_a_r[`ICC_EA_SERIAL_A],
      irq_enable_reg_b_r[`ICC_EB_EXT_E], irq_enable_reg_a_r[`ICC_EA_TIMER_B],
      irq_enable_reg_b_r[`ICC_EB_EXT_D], irq_enable_reg_a_r[`ICC_EA_EXT_B],
      irq_enable_reg_b_r[`ICC_EB_EXT_C], irq_enable_reg_a_r[`ICC_EA_TIMER_A],
      irq_enable_reg_c_r[`ICC_EC_SERIAL_B], irq_enable_reg_a_r[`ICC_EA_EXT_A]};

   // Pending and enabled
   wire [`ICC_NSRC-1:0] cand = req & en & {`ICC_NSRC{irq_enable_reg_a_r[`ICC_EA_GLOBAL]}};

   // Level per source: group is index over two
   logic [1:0] lvl [`ICC_NSRC];
   genvar gs;
   generate
      for (gs = 0; gs < `ICC_NSRC; gs++) begin : g_lvl
         assign lvl[gs] = {irq_priority_reg_b_r[gs/2], irq_priority_reg_a_r[gs/2]};
      end
   endgenerate

   // Winner: highest level, earliest in polling order on a tie
   logic       win_ok;
   logic [3:0] win_idx;
   logic [1:0] win_lvl;
   always_comb begin
      win_ok  = 1'b0;
      win_idx = 4'h0;
      win_lvl = 2'h0;
      for (int i = `ICC_NSRC - 1; i >= 0; i--) begin
         if (cand[i] && (!win_ok || lvl[i] >= win_lvl)) begin
            win_ok  = 1'b1;
            win_idx = 4'(i);
            win_lvl = lvl[i];
         end
      end
   end

   // Highest active service level
   wire       svc_any = |svc_r;
   wire [1:0] top_lvl = svc_r[3] ? 2'h3 : svc_r[2] ? 2'h2 : svc_r[1] ? 2'h1 : 2'h0;
   wire       preempt_ok = !svc_any || (win_lvl > top_lvl);

   // Take the call at the instruction boundary after detection
   wire       take = sel_ok_r & core_in.instr_cycle & (busy_cnt_r == 3'h0);
   wire [3:0] take_mask = take ? (4'h1 << sel_lvl_r) : 4'h0;
   wire [3:0] return_from_interrupt_instruction_mask = !core_in.return_from_interrupt_instruction ? 4'h0 :
                          svc_r[3] ? 4'h8 : svc_r[2] ? 4'h4 : svc_r[1] ? 4'h2 : svc_r[0] ? 4'h1 : 4'h0;
   wire [3:0] svc_nxt = (svc_r & ~return_from_interrupt_instruction_mask) | take_mask;

   // Hardware clears of the timer A and B flags on their call
   wire       clr_tim_a = take & (sel_idx_r == 4'h2);
   wire       clr_tim_b = take & (sel_idx_r == 4'h6);
   wire [7:0] tc_clr = ({7'h00, clr_tim_a} << `ICC_TC_TIMER_A) | ({7'h00, clr_tim_b} << `ICC_TC_TIMER_B);

   // Flag next values: hardware set wins over clear
   wire [7:0] tc_nxt = ((wr_tc ? wd : timer_control_reg_r) & ~tc_clr) | tc_set;
   wire [7:0] ir_nxt = (wr_ir ? wd : irq_request_reg_r) | ir_set;
   wire [7:0] sa_nxt = (wr_sa ? wd : serial_a_control_reg_r) | sa_set;
   wire [7:0] sb_nxt = (wr_sb ? wd : serial_b_control_reg_r) | sb_set;
   wire [`ICC_NSRC-1:0] es_nxt = (evt_st_r & ~(wr_es ? hwdata[`ICC_NSRC-1:0] : `ICC_EVT_RST)) | evt_set;

   // Vector lookup
   logic [15:0] sel_vec;
   always_comb begin
      unique case (sel_idx_r)
         4'h0:    sel_vec = `ICC_VEC_EXT_A;
         4'h1:    sel_vec = `ICC_VEC_SERIAL_B;
         4'h2:    sel_vec = `ICC_VEC_TIMER_A;
         4'h3:    sel_vec = `ICC_VEC_EXT_C;
         4'h4:    sel_vec = `ICC_VEC_EXT_B;
         4'h5:    sel_vec = `ICC_VEC_EXT_D;
         4'h6:    sel_vec = `ICC_VEC_TIMER_B;
         4'h7:    sel_vec = `ICC_VEC_EXT_E;
         4'h8:    sel_vec = `ICC_VEC_SERIAL_A;
         4'h9:    sel_vec = `ICC_VEC_EXT_F;
         4'ha:    sel_vec = `ICC_VEC_TIMER_C;
         4'hb:    sel_vec = `ICC_VEC_EXT_G;
         default: sel_vec = `ICC_VEC_EXT_A;
      endcase
   end

   // Read mux
   logic [7:0] rd_byte;
   logic [`ICC_NSRC-1:0] rd_wide;
   always_comb begin
      rd_byte = 8'h00;
      rd_wide = `ICC_EVT_RST;
      unique case (addr_r)
         `ICC_OFS_TIMER_CTRL:    rd_byte = timer_control_reg_r;
         `ICC_OFS_IRQ_REQUEST:   rd_byte = irq_request_reg_r;
         `ICC_OFS_TIMER_C_CTRL:  rd_byte = timer_c_control_reg_r;
         `ICC_OFS_SERIAL_A_CTRL: rd_byte = serial_a_control_reg_r;
         `ICC_OFS_SERIAL_B_CTRL: rd_byte = serial_b_control_reg_r;
         `ICC_OFS_ENABLE_A:      rd_byte = irq_enable_reg_a_r;
         `ICC_OFS_ENABLE_B:      rd_byte = irq_enable_reg_b_r;
         `ICC_OFS_ENABLE_C:      rd_byte = irq_enable_reg_c_r;
         `ICC_OFS_PRIO_A:        rd_byte = irq_priority_reg_a_r;
         `ICC_OFS_PRIO_B:        rd_byte = irq_priority_reg_b_r;
         `ICC_OFS_EVT_STATUS:    rd_wide = evt_st_r;
         `ICC_OFS_EVT_MASK:      rd_wide = evt_mask_r;
         `ICC_OFS_SVC_STATUS:    rd_byte = {busy_cnt_r != 3'h0, 3'h0, svc_r};
         default:                rd_byte = 8'h00;
      endcase
   end
   wire [31:0] rd_word = {20'h00000, rd_wide} | {24'h000000, rd_byte};

   // Bus sequencing: reads take one wait state
   always_comb begin
      unique case (bus_st_r)
         ST_RDW:  bus_st_nxt = ST_RDD;
         default: bus_st_nxt = addr_ok ? (hwrite ? ST_WR : ST_RDW) : ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_st_r    <= ST_IDLE;
         addr_r      <= `ICC_REG_RST;
         hreadyout_r <= 1'b1;
         hrdata_r    <= 32'h00000000;
      end else begin
         bus_st_r    <= bus_st_nxt;
         hreadyout_r <= (bus_st_nxt != ST_RDW);
         if (addr_ok) begin
            addr_r <= haddr[`ICC_ADDR_W-1:0];
         end
         if (bus_st_r == ST_RDW) begin
            hrdata_r <= rd_word;
         end
      end
   end

   // Flags and configuration, all cleared at reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_control_reg_r    <= `ICC_REG_RST;
         irq_request_reg_r      <= `ICC_REG_RST;
         timer_c_control_reg_r  <= `ICC_REG_RST;
         serial_a_control_reg_r <= `ICC_REG_RST;
         serial_b_control_reg_r <= `ICC_REG_RST;
         irq_enable_reg_a_r     <= `ICC_REG_RST;
         irq_enable_reg_b_r     <= `ICC_REG_RST;
         irq_enable_reg_c_r     <= `ICC_REG_RST;
         irq_priority_reg_a_r   <= `ICC_REG_RST;
         irq_priority_reg_b_r   <= `ICC_REG_RST;
         evt_st_r               <= `ICC_EVT_RST;
         evt_mask_r             <= `ICC_EVT_RST;
         irq_r                  <= 1'b0;
      end else begin
         timer_control_reg_r    <= tc_nxt;
         irq_request_reg_r      <= ir_nxt;
         serial_a_control_reg_r <= sa_nxt;
         serial_b_control_reg_r <= sb_nxt;
         evt_st_r               <= es_nxt;
         irq_r                  <= |(es_nxt & evt_mask_r);
         if (wr_t2) timer_c_control_reg_r <= wd;
         if (wr_ea) irq_enable_reg_a_r <= wd;
         if (wr_eb) irq_enable_reg_b_r <= wd;
         if (wr_ec) irq_enable_reg_c_r <= wd;
         if (wr_pa) irq_priority_reg_a_r <= wd;
         if (wr_pb) irq_priority_reg_b_r <= wd;
         if (wr_em) evt_mask_r <= hwdata[`ICC_NSRC-1:0];
      end
   end

   // Detection stage and forced call
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_ok_r   <= 1'b0;
         sel_idx_r  <= 4'h0;
         sel_lvl_r  <= 2'h0;
         svc_r      <= 4'h0;
         busy_cnt_r <= 3'h0;
         call_r     <= '0;
      end else begin
         sel_ok_r   <= win_ok & preempt_ok & ~take;
         sel_idx_r  <= win_idx;
         sel_lvl_r  <= win_lvl;
         svc_r      <= svc_nxt;
         call_r.req <= take;
         if (take) begin
            call_r.vec <= sel_vec;
            call_r.lvl <= sel_lvl_r;
            busy_cnt_r <= `ICC_CALL_CYCLES;
         end else if (busy_cnt_r != 3'h0) begin
            busy_cnt_r <= busy_cnt_r - 3'h1;
         end
      end
   end

   assign hreadyout  = hreadyout_r;
   assign hrdata     = hrdata_r;
   assign hresp      = 1'b0;
   assign call_out   = call_r;
   assign svc_levels = svc_r;
   assign irq        = irq_r;
endmodule

// *** core/icc_defines.svh ***
// Purpose: Offsets, bit positions, reset values and timing counts of the interrupt controller
// Assumes: AHB-Lite byte addresses, one 32-bit word per register, 8-bit register data except the 12-bit event status and mask
// Notes:   Definitions only
`ifndef ICC_DEFINES_SVH
`define ICC_DEFINES_SVH

// Register byte addresses, compared against haddr[7:0]
`define ICC_ADDR_W            8
`define ICC_OFS_TIMER_CTRL    8'h00
`define ICC_OFS_IRQ_REQUEST   8'h04
`define ICC_OFS_TIMER_C_CTRL  8'h08
`define ICC_OFS_SERIAL_A_CTRL 8'h0c
`define ICC_OFS_SERIAL_B_CTRL 8'h10
`define ICC_OFS_ENABLE_A      8'h14
`define ICC_OFS_ENABLE_B      8'h18
`define ICC_OFS_ENABLE_C      8'h1c
`define ICC_OFS_PRIO_A        8'h20
`define ICC_OFS_PRIO_B        8'h24
`define ICC_OFS_EVT_STATUS    8'h28
`define ICC_OFS_EVT_MASK      8'h2c
`define ICC_OFS_SVC_STATUS    8'h30

`define ICC_REG_RST           8'h00
`define ICC_EVT_RST           12'h000
`define ICC_NSRC              12
`define ICC_NPIN              7

// Timer control register bits
`define ICC_TC_EDGE_A         0
`define ICC_TC_FLAG_A         1
`define ICC_TC_EDGE_B         2
`define ICC_TC_FLAG_B         3
`define ICC_TC_TIMER_A        5
`define ICC_TC_TIMER_B        7
// Request register bits
`define ICC_IR_EXT_C          1
`define ICC_IR_EXT_D          2
`define ICC_IR_EXT_E          3
`define ICC_IR_EXT_F          4
`define ICC_IR_EXT_G          5
`define ICC_IR_TIMER_C_EXT    6
`define ICC_IR_TIMER_C_OVF    7
// Timer C control register bits: 1 selects rising edge
`define ICC_T2_RISE_C         5
`define ICC_T2_RISE_D         6
// Serial control register bits
`define ICC_SC_RX             0
`define ICC_SC_TX             1
// Enable register A bits
`define ICC_EA_EXT_A          0
`define ICC_EA_TIMER_A        1
`define ICC_EA_EXT_B          2
`define ICC_EA_TIMER_B        3
`define ICC_EA_SERIAL_A       4
`define ICC_EA_TIMER_C        5
`define ICC_EA_GLOBAL         7
// Enable register B bits
`define ICC_EB_EXT_C          0
`define ICC_EB_EXT_D          1
`define ICC_EB_EXT_E          2
`define ICC_EB_EXT_F          3
`define ICC_EB_EXT_G          4
// Enable register C bits
`define ICC_EC_SERIAL_B       0

// Vectors in polling order
`define ICC_VEC_EXT_A         16'h0003
`define ICC_VEC_SERIAL_B      16'h0083
`define ICC_VEC_TIMER_A       16'h000b
`define ICC_VEC_EXT_C         16'h004b
`define ICC_VEC_EXT_B         16'h0013
`define ICC_VEC_EXT_D         16'h0053
`define ICC_VEC_TIMER_B       16'h001b
`define ICC_VEC_EXT_E         16'h005b
`define ICC_VEC_SERIAL_A      16'h0023
`define ICC_VEC_EXT_F         16'h0063
`define ICC_VEC_TIMER_C       16'h002b
`define ICC_VEC_EXT_G         16'h006b

// Detect takes one cycle, the forced call six
`define ICC_DETECT_CYCLES     1
`define ICC_CALL_CYCLES       3'h6

`endif

// *** core/icc_pin_edge.sv ***
// Purpose: Synchronise one interrupt pin and report its level and edges
// Assumes: Pin is asynchronous to hclk
// Notes:   Edges are one-cycle pulses
`timescale 1ns/1ps
module icc_pin_edge (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic pin_raw,
   output logic      pin_low,
   output logic      pin_rise,
   output logic      pin_fall
);
   logic sync1_r;
   logic sync2_r;
   logic prev_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         prev_r  <= 1'b1;
      end else begin
         sync1_r <= pin_raw;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   assign pin_low  = ~sync2_r;
   assign pin_rise = sync2_r & ~prev_r;
   assign pin_fall = ~sync2_r & prev_r;
endmodule

// *** core/icc_pkg.sv ***
// Purpose: Types of the interrupt controller
// Assumes: Used by icc_ctrl and the verification files
// Notes:   Constants live in icc_defines.svh
package icc_pkg;

   typedef enum logic [1:0] {ST_IDLE, ST_WR, ST_RDW, ST_RDD} icc_bus_e;

   typedef struct packed {
      logic       timer_a_ovf;
      logic       timer_b_ovf;
      logic       timer_c_ovf;
      logic       timer_c_ext;
      logic       serial_a_rx;
      logic       serial_a_tx;
      logic       serial_b_rx;
      logic       serial_b_tx;
      logic [3:0] cc_evt;
   } icc_periph_s;

   typedef struct packed {
      logic instr_cycle;
      logic return_from_interrupt_instruction;
   } icc_core_s;

   typedef struct packed {
      logic        req;
      logic [15:0] vec;
      logic [1:0]  lvl;
   } icc_call_s;

endpackage

// *** verif/icc_core_model.sv ***
// Purpose: Instruction sequencer facing the controller
// Assumes: Boundary every other cycle outside calls
// Notes:   Return pulse on bench command
`timescale 1ns/1ps
module icc_core_model (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire icc_pkg::icc_call_s call_out,
   input  wire logic               return_from_interrupt_instruction_cmd,
   output icc_pkg::icc_core_s      core_in
);
   import icc_pkg::*;
   logic [2:0] busy_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_r  <= 3'h0;
         core_in <= '0;
      end else begin
         busy_r              <= call_out.req ? 3'h6 : (busy_r != 3'h0) ? busy_r - 3'h1 : 3'h0;
         core_in.instr_cycle <= busy_r == 3'h0 && !call_out.req && !core_in.instr_cycle;
         core_in.return_from_interrupt_instruction        <= return_from_interrupt_instruction_cmd;
      end
   end
endmodule

// *** verif/icc_ctrl_sva.sv ***
// Purpose: Port assertions of the controller
// Assumes: Bound to icc_ctrl, one clock
// Notes:   Returns never meet calls
`timescale 1ns/1ps
module icc_ctrl_sva (
   input wire logic               hclk,
   input wire logic               hresetn,
   input wire logic               hsel,
   input wire logic [1:0]         htrans,
   input wire logic               hwrite,
   input wire logic               hready,
   input wire logic               hreadyout,
   input wire icc_pkg::icc_core_s core_in,
   input wire icc_pkg::icc_call_s call_out,
   input wire logic [3:0]         svc_levels
);
   import icc_pkg::*;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_read_answer; !hreadyout ##1 hreadyout; endsequence
   sequence s_call_quiet; !call_out.req [*5]; endsequence
   a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> s_read_answer)
      else $error("read wait wrong");
   a_call_gap: assert property (call_out.req |=> s_call_quiet)
      else $error("call too soon");
   a_call_on_instr: assert property (call_out.req |-> $past(core_in.instr_cycle))
      else $error("call off boundary");
   a_vec_legal: assert property (call_out.req |-> call_out.vec inside
      {16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b, 16'h0083, 16'h004b, 16'h0053, 16'h005b,
       16'h0063, 16'h006b}) else $error("bad vector");
   a_svc_marks: assert property (call_out.req |->
      svc_levels == ($past(svc_levels) | (4'h1 << call_out.lvl))) else $error("level not marked");
   a_preempt_high: assert property (call_out.req |-> ($past(svc_levels) >> call_out.lvl) == 4'h0)
      else $error("weak preemption");
   a_return_from_interrupt_instruction_ends: assert property (core_in.return_from_interrupt_instruction && svc_levels != 4'h0 |=>
      call_out.req || svc_levels < $past(svc_levels)) else $error("level kept");
   a_vec_hold: assert property (!call_out.req |-> $stable(call_out.vec) && $stable(call_out.lvl))
      else $error("vector moved");
endmodule

// *** verif/tb_twelve_source_interrupt_controller.sv ***
// Purpose: Self-checking bench of the controller
// Assumes: Core model answers calls
// Notes:   Row loop, then hand tests
`timescale 1ns/1ps
module tb_twelve_source_interrupt_controller;
   import icc_pkg::*;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, return_from_interrupt_instruction_cmd = 0, hreadyout, hresp, irq;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0]  htrans = 0;
   logic [7:0]  pins = 8'hff, rp, ro, rf;
   logic [11:0] re;
   logic [15:0] rv, vec_seen = 0;
   logic [3:0]  svc_levels, rx;
   icc_periph_s periph_evt = '0;
   icc_core_s   core_in;
   icc_call_s   call_out;
   int          miscompares = 0, checks = 0, reqs = 0, cyc = 0, r;
   logic [55:0] rows [19] = '{56'h01000000300020, 56'h00020008310011, 56'h00010008310021, 56'h00800000b00002,
      56'h04000004b04023, 56'h02000001300084, 56'h08000005304045, 56'h00001005304045, 56'h00400001b00006,
      56'h10000005b04087, 56'h00002005b04087, 56'h0004000230c028, 56'h0008000230c018, 56'h20000006304109,
      56'h00004006304109, 56'h00200002b0480a, 56'h00100002b0440a, 56'h40000006b0420b, 56'h00008006b0420b};
   always #25 hclk = ~hclk;
   icc_ctrl icc_ctrl_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
      .hreadyout, .hrdata, .hresp, .ext_irq_pin_a(pins[0]), .ext_irq_pin_b(pins[1]), .ext_irq_pin_c(pins[2]),
      .ext_irq_pin_d(pins[3]), .ext_irq_pin_e(pins[4]), .ext_irq_pin_f(pins[5]), .ext_irq_pin_g(pins[6]),
      .periph_evt, .core_in, .call_out, .svc_levels, .irq);
   icc_core_model icc_core_model_i (.hclk, .hresetn, .call_out, .return_from_interrupt_instruction_cmd, .core_in);
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (call_out.req === 1'b1) begin
         reqs     <= reqs + 1;
         vec_seen <= call_out.vec;
      end
      if (cyc > 6000) begin
         miscompares++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value at %0t: saw %h, expected %h", $time, s, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 0; htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic fire(input logic [7:0] p, input logic [11:0] ev);
      @(posedge hclk);
      pins <= ~p; periph_evt <= ev;
      @(posedge hclk);
      periph_evt <= '0;
      repeat (2) @(posedge hclk);
      pins <= 8'hff;
      repeat (16) @(posedge hclk);
   endtask
   task automatic ret();
      @(posedge hclk) return_from_interrupt_instruction_cmd <= 1;
      @(posedge hclk) return_from_interrupt_instruction_cmd <= 0;
      repeat (12) @(posedge hclk);
   endtask
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1;
      fire(0, 12'h800);
      chk(reqs, 0); chk(irq, 0);
      bus(0, 8'h00, 0); chk(q, 32'h20);
      bus(0, 8'h40, 0); chk(q, 0); chk(hresp, 0);
      bus(1, 8'h00, 0); bus(1, 8'h28, 32'hfff); bus(1, 8'h14, 32'hbf);
      bus(1, 8'h18, 32'h1f); bus(1, 8'h1c, 32'h1); bus(1, 8'h2c, 32'hfff);
      foreach (rows[i]) begin
         {rp, re, rv, ro, rf, rx} = rows[i];
         r = reqs;
         fire(rp, re);
         chk(reqs - r, 1); chk(vec_seen, rv);
         bus(0, ro, 0); chk(q, rf);
         bus(0, 8'h28, 0); chk(q, 32'h1 << rx); chk(irq, 1);
         bus(1, ro, 0); bus(1, 8'h28, 32'hfff); ret();
         chk({irq, svc_levels}, 0);
      end
      bus(1, 8'h20, 32'h08);
      r = reqs;
      fire(0, 12'hc00);
      chk(vec_seen, 16'h001b); chk(svc_levels, 4'h2);
      chk(reqs - r, 1);
      bus(1, 8'h24, 32'h01);
      fire(0, 12'h020); bus(1, 8'h10, 0);
      chk(vec_seen, 16'h0083); chk(svc_levels, 4'h6);
      ret();
      chk(svc_levels, 4'h2);
      ret();
      chk(vec_seen, 16'h000b); chk(svc_levels, 4'h1);
      report_and_stop();
   end
endmodule
bind icc_ctrl icc_ctrl_sva icc_ctrl_sva_i (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .core_in,
   .call_out, .svc_levels);
